// *** design/slcr_config_regs.sv ***
// Link configuration register pair: rate, width, parity and spread control
`timescale 1ns/1ns
module slcr_config_regs
	import slcr_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic [7:0]    reg_addr,
	input  wire logic          reg_wr_en,
	input  wire logic [7:0]    reg_wr_data,
	input  wire logic          reg_rd_en,
	output logic [7:0]         reg_rd_data,
	output logic               reg_rd_valid,
	output logic               reg_addr_error,
	output logic               cfg_changed,
	output slcr_link_cfg_type  link_cfg,
	output slcr_cfg_status_type cfg_status
);

	// ********************************************************************
	// Stored registers
	// ********************************************************************
	logic [7:0]          rate_width_ff;
	logic [7:0]          spread_ff;
	logic [7:0]          nxt_rate_width;
	logic [7:0]          nxt_spread;

	// ********************************************************************
	// Output flops
	// ********************************************************************
	logic [7:0]          rd_data_ff;
	logic [7:0]          nxt_rd_data;
	logic                rd_valid_ff;
	logic                nxt_rd_valid;
	logic                addr_error_ff;
	logic                nxt_addr_error;
	logic                changed_ff;
	logic                nxt_changed;
	slcr_link_cfg_type   link_cfg_ff;
	slcr_cfg_status_type status_ff;

	// ********************************************************************
	// Address decode
	// ********************************************************************
	wire                 hit_rate_width;
	wire                 hit_spread;
	wire                 hit_any;
	wire                 wr_rate_width;
	wire                 wr_spread;
	wire [7:0]           rd_mux;

	assign hit_rate_width = (reg_addr == SLCR_ADDR_RATE_WIDTH);
	assign hit_spread     = (reg_addr == SLCR_ADDR_SPREAD);
	assign hit_any        = hit_rate_width || hit_spread;
	assign wr_rate_width  = reg_wr_en && hit_rate_width;
	assign wr_spread      = reg_wr_en && hit_spread;

	assign nxt_rate_width = wr_rate_width ? reg_wr_data : rate_width_ff;
	assign nxt_spread     = wr_spread ? reg_wr_data : spread_ff;

	assign rd_mux = hit_rate_width ? rate_width_ff :
		hit_spread ? spread_ff : 8'h00;

	// Read value holds until the next read
	assign nxt_rd_data = reg_rd_en ? rd_mux : rd_data_ff;

	// Unmapped reads still answer, with a zero byte
	assign nxt_rd_valid = reg_rd_en;

	// ********************************************************************
	// Unmapped access detection
	// ********************************************************************
	wire                 wr_unmapped;
	wire                 rd_unmapped;

	// Unmapped access flagged, never stored
	// Error pulse only; the read port still answers
	assign wr_unmapped    = reg_wr_en && !hit_any;
	assign rd_unmapped    = reg_rd_en && !hit_any;
	assign nxt_addr_error = wr_unmapped || rd_unmapped;

	// ********************************************************************
	// Change detection
	// ********************************************************************
	wire                 rate_width_moved;
	wire                 spread_moved;

	// Only a real value change pulses, so the link need not relock
	// Reset reload is not a write and raises no pulse
	assign rate_width_moved = (nxt_rate_width != rate_width_ff);
	assign spread_moved     = (nxt_spread != spread_ff);
	assign nxt_changed      = rate_width_moved || spread_moved;

	// ********************************************************************
	// Field extraction
	// ********************************************************************
	slcr_link_cfg_type   cfg_fields;
	slcr_cfg_status_type cfg_decoded;

	assign cfg_fields.pixel_clock_range =
		rate_width_ff[SLCR_PIX_LSB +: 2];
	assign cfg_fields.serial_rate_range =
		rate_width_ff[SLCR_SER_LSB +: 2];
	assign cfg_fields.parity_on = rate_width_ff[SLCR_PAR_BIT];
	assign cfg_fields.parallel_word_width =
		rate_width_ff[SLCR_WID_LSB +: 3];
	assign cfg_fields.spread_code = spread_ff[SLCR_SPR_LSB +: 3];
	assign cfg_fields.reserved_bits = spread_ff[SLCR_RESV_LSB +: 5];

	// ********************************************************************
	// Derived operating values
	// ********************************************************************
	slcr_field_decode u_decode (
		.cfg    (cfg_fields),
		.status (cfg_decoded)
	);

	// ********************************************************************
	// Register storage
	// ********************************************************************
	// Defaults on reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rate_width_ff <= SLCR_RATE_WIDTH_RST;
		end else begin
			rate_width_ff <= nxt_rate_width;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			spread_ff <= SLCR_SPREAD_RST;
		end else begin
			spread_ff <= nxt_spread;
		end
	end

	// ********************************************************************
	// Read port
	// ********************************************************************
	// Read data register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// ********************************************************************
	// Event pulses
	// ********************************************************************
	// Unmapped offset error pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr_error_ff <= 1'b0;
		end else begin
			addr_error_ff <= nxt_addr_error;
		end
	end

	// Stored value change pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			changed_ff <= 1'b0;
		end else begin
			changed_ff <= nxt_changed;
		end
	end

	// ********************************************************************
	// Configuration outputs
	// ********************************************************************
	// Extra stage keeps outputs flop-driven; lags storage by one cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			link_cfg_ff <= {SLCR_RATE_WIDTH_RST, SLCR_SPREAD_RST};
		end else begin
			link_cfg_ff <= cfg_fields;
		end
	end

	// Cap violation reported
	// Over-limit spread is stored; writes are never refused
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status_ff <= '0;
		end else begin
			status_ff <= cfg_decoded;
		end
	end

	assign reg_rd_data    = rd_data_ff;
	assign reg_rd_valid   = rd_valid_ff;
	assign reg_addr_error = addr_error_ff;
	assign cfg_changed    = changed_ff;
	assign link_cfg       = link_cfg_ff;
	assign cfg_status     = status_ff;

endmodule

// *** design/slcr_pkg.sv ***
// Shared constants, field layouts and carrier types for the link config regs
package slcr_pkg;

	// ********************************************************************
	// Register offsets on the control-channel register port
	// ********************************************************************
	localparam logic [7:0] SLCR_ADDR_RATE_WIDTH = 8'h00;
	localparam logic [7:0] SLCR_ADDR_SPREAD     = 8'h01;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int SLCR_PIX_LSB    = 6;
	localparam int SLCR_SER_LSB    = 4;
	localparam int SLCR_PAR_BIT    = 3;
	localparam int SLCR_WID_LSB    = 0;
	localparam int SLCR_SPR_LSB    = 5;
	localparam int SLCR_RESV_LSB   = 0;

	// ********************************************************************
	// Field reset values
	// ********************************************************************
	localparam logic [1:0] SLCR_PIX_RST    = 2'h2;
	localparam logic [1:0] SLCR_SER_RST    = 2'h3;
	localparam logic       SLCR_PAR_RST    = 1'h0;
	localparam logic [2:0] SLCR_WID_RST    = 3'h5;
	localparam logic [2:0] SLCR_SPR_RST    = 3'h0;
	localparam logic [4:0] SLCR_RESV_RST   = 5'h1F;

	localparam logic [7:0] SLCR_RATE_WIDTH_RST = {SLCR_PIX_RST, SLCR_SER_RST,
		SLCR_PAR_RST, SLCR_WID_RST};
	localparam logic [7:0] SLCR_SPREAD_RST     = {SLCR_SPR_RST, SLCR_RESV_RST};

	// ********************************************************************
	// Decoding constants
	// ********************************************************************
	localparam logic [1:0] SLCR_PIX_HIGH_MIN   = 2'h2;
	localparam logic [4:0] SLCR_WIDTH_BASE     = 5'h0A;
	localparam logic [4:0] SLCR_WIDTH_MAX      = 5'h12;
	localparam logic [4:0] SLCR_PARITY_MAX_WID = 5'h10;
	localparam logic [8:0] SLCR_SPR_1P50       = 9'h096;
	localparam logic [8:0] SLCR_SPR_1P75       = 9'h0AF;
	localparam logic [8:0] SLCR_SPR_2P00       = 9'h0C8;
	localparam logic [8:0] SLCR_SPR_3P00       = 9'h12C;
	localparam logic [8:0] SLCR_SPR_3P50       = 9'h15E;
	localparam logic [8:0] SLCR_SPR_4P00       = 9'h190;
	localparam logic [8:0] SLCR_SPR_HIGH_LIMIT = SLCR_SPR_2P00;

	// ********************************************************************
	// Carrier types
	// ********************************************************************
	typedef struct packed {
		logic [1:0] pixel_clock_range;
		logic [1:0] serial_rate_range;
		logic       parity_on;
		logic [2:0] parallel_word_width;
		logic [2:0] spread_code;
		logic [4:0] reserved_bits;
	} slcr_link_cfg_type;

	typedef struct packed {
		logic [4:0] word_bits;
		logic [8:0] spread_hundredths;
		logic       spread_active;
		logic       spread_over_limit;
		logic       parity_unsupported;
		logic       reserved_not_ones;
	} slcr_cfg_status_type;

	// Hundredths of a percent; codes 000 and 100 both mean off
	function automatic logic [8:0] slcr_spread_decode(input logic [2:0] code);
		case (code)
			3'h1:    slcr_spread_decode = SLCR_SPR_1P50;
			3'h2:    slcr_spread_decode = SLCR_SPR_1P75;
			3'h3:    slcr_spread_decode = SLCR_SPR_2P00;
			3'h5:    slcr_spread_decode = SLCR_SPR_3P00;
			3'h6:    slcr_spread_decode = SLCR_SPR_3P50;
			3'h7:    slcr_spread_decode = SLCR_SPR_4P00;
			default: slcr_spread_decode = 9'h000;
		endcase
	endfunction

	// Word bits incl. sync, step of two, held at the widest word
	function automatic logic [4:0] slcr_width_decode(input logic [2:0] code);
		logic [4:0] bits;
		bits = SLCR_WIDTH_BASE + {1'b0, code, 1'b0};
		slcr_width_decode = (bits > SLCR_WIDTH_MAX) ? SLCR_WIDTH_MAX : bits;
	endfunction

endpackage

// *** design/slcr_field_decode.sv ***
// Decodes stored configuration fields into derived operating values
`timescale 1ns/1ns
module slcr_field_decode
	import slcr_pkg::*;
(
	input  slcr_link_cfg_type   cfg,
	output slcr_cfg_status_type status
);

	wire [8:0] spread_val;
	wire [4:0] width_val;
	wire       pix_high;

	assign spread_val = slcr_spread_decode(cfg.spread_code);
	assign width_val  = slcr_width_decode(cfg.parallel_word_width);
	assign pix_high   = (cfg.pixel_clock_range >= SLCR_PIX_HIGH_MIN);

	assign status.word_bits          = width_val;
	assign status.spread_hundredths  = spread_val;
	assign status.spread_active      = (spread_val != 9'h000);
	assign status.spread_over_limit  = pix_high &&
		(spread_val > SLCR_SPR_HIGH_LIMIT);
	assign status.parity_unsupported = cfg.parity_on &&
		(width_val > SLCR_PARITY_MAX_WID);
	assign status.reserved_not_ones  = (cfg.reserved_bits != SLCR_RESV_RST);

endmodule

// *** verification/slcr_config_regs_properties.sv ***
// Timing checks on the link config register port
`timescale 1ns/1ns
module slcr_config_regs_properties
	import slcr_pkg::*;
(
	input wire logic                clock,
	input wire logic                rst_n,
	input wire logic [7:0]          reg_addr,
	input wire logic                reg_wr_en,
	input wire logic [7:0]          reg_wr_data,
	input wire logic                reg_rd_en,
	input wire logic [7:0]          reg_rd_data,
	input wire logic                reg_rd_valid,
	input wire logic                reg_addr_error,
	input wire logic                cfg_changed,
	input wire slcr_link_cfg_type   link_cfg,
	input wire slcr_cfg_status_type cfg_status
);
	// ****************************************************************
	// Helpers and properties
	// ****************************************************************
	wire logic       wr0 = reg_wr_en && reg_addr == SLCR_ADDR_RATE_WIDTH;
	wire logic       wr1 = reg_wr_en && reg_addr == SLCR_ADDR_SPREAD;
	wire logic       unm = (reg_wr_en || reg_rd_en) && reg_addr > 8'h01;
	wire logic       urd = reg_rd_en && reg_addr > 8'h01;
	wire logic [2:0] wc  = link_cfg.parallel_word_width;
	wire logic [2:0] sc  = link_cfg.spread_code;
	// Designer clamps widths above code 100 at the widest word
	wire logic [4:0] xb  = (wc > 3'h4) ? 5'h12 : 5'h0A + {1'b0, wc, 1'b0};
	wire logic       hi  = sc[2] && sc[1:0] != 2'h0;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_rd; reg_rd_en |=> reg_rd_valid; endproperty
	a_rd: assert property (p_rd) else $error("no read valid");
	property p_unm; unm |=> reg_addr_error; endproperty
	a_unm: assert property (p_unm) else $error("unmapped flag");
	property p_urd; urd |=> reg_rd_valid && reg_rd_data == 8'h00;
	endproperty
	a_urd: assert property (p_urd) else $error("unmapped read");
	property p_wr0; wr0 |-> ##2 link_cfg[15:8] == $past(reg_wr_data, 2);
	endproperty
	a_wr0: assert property (p_wr0) else $error("rate fields");
	property p_wr1; wr1 |-> ##2 link_cfg[7:0] == $past(reg_wr_data, 2);
	endproperty
	a_wr1: assert property (p_wr1) else $error("spread fields");
	property p_wid; $stable(link_cfg)[*3] |-> cfg_status.word_bits == xb;
	endproperty
	a_wid: assert property (p_wid) else $error("word bits");
	property p_act; $stable(link_cfg)[*3] |->
		cfg_status.spread_active == (sc[1:0] != 2'h0); endproperty
	a_act: assert property (p_act) else $error("spread active");
	property p_ovr; $stable(link_cfg)[*3] |->
		cfg_status.spread_over_limit ==
		(link_cfg.pixel_clock_range[1] && hi);
	endproperty
	a_ovr: assert property (p_ovr) else $error("over limit");
	property p_chg; cfg_changed |=> $changed(link_cfg); endproperty
	a_chg: assert property (p_chg) else $error("change flag");
	property p_kep; !cfg_changed |=> $stable(link_cfg); endproperty
	a_kep: assert property (p_kep) else $error("config moved");
endmodule
bind slcr_config_regs slcr_config_regs_properties
	u_slcr_config_regs_properties (
	.clock, .rst_n, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
	.reg_rd_data, .reg_rd_valid, .reg_addr_error, .cfg_changed, .link_cfg,
	.cfg_status);

// *** verification/slcr_ecu_model.sv ***
// Control unit model that drives the register port
`timescale 1ns/1ns
module slcr_ecu_model
	import slcr_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	output logic [7:0]      reg_addr,
	output logic            reg_wr_en,
	output logic [7:0]      reg_wr_data,
	output logic            reg_rd_en,
	input  wire logic [7:0] reg_rd_data,
	input  wire logic       reg_rd_valid
);
	// ****************************************************************
	// Access tasks
	// ****************************************************************
	logic [1:0] pix;
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
		pix = SLCR_PIX_RST;
	end
	always @(posedge clock) if (!rst_n) pix = SLCR_PIX_RST;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == SLCR_ADDR_SPREAD) v[4:0] = SLCR_RESV_RST;
		if (a == SLCR_ADDR_SPREAD && pix[1] && v[7] && v[6:5] != 2'h0)
			v[7:5] = 3'h3;
		if (a == SLCR_ADDR_RATE_WIDTH) pix = v[7:6];
		@(negedge clock);
		reg_addr = a;
		reg_wr_data = v;
		reg_wr_en = 1'b1;
		@(negedge clock);
		reg_wr_en = 1'b0;
		// Released data shows no stale value
		reg_wr_data = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(negedge clock);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clock);
		reg_rd_en = 1'b0;
		d = reg_rd_data;
		ok = reg_rd_valid;
	endtask
endmodule

// *** verification/slcr_config_regs_tb_top.sv ***
// Self-checking bench for the link config register pair
`timescale 1ns/1ns
module slcr_config_regs_tb_top
	import slcr_pkg::*;
();
	// ****************************************************************
	// Bench
	// ****************************************************************
	logic                clock = 1'b0;
	logic                rst_n = 1'b0;
	logic [7:0]          reg_addr, reg_wr_data, reg_rd_data, rd_d;
	logic                reg_wr_en, reg_rd_en, reg_rd_valid, rd_v;
	logic                reg_addr_error, cfg_changed;
	slcr_link_cfg_type   link_cfg;
	slcr_cfg_status_type cfg_status;
	int                  num_errors = 0;
	int                  checks = 0;
	always #2 clock = ~clock;
	slcr_config_regs u_slcr_config_regs (.clock, .rst_n, .reg_addr,
		.reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid,
		.reg_addr_error, .cfg_changed, .link_cfg, .cfg_status);
	slcr_ecu_model u_slcr_ecu_model (.clock, .rst_n, .reg_addr, .reg_wr_en,
		.reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid);
	task automatic cmp(input string n, input logic [17:0] e,
		input logic [17:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
		input logic [7:0] e);
		u_slcr_ecu_model.rd(a, rd_d, rd_v);
		cmp(n, {10'h001, e}, {9'h0, rd_v, rd_d});
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		results;
	end
	initial begin
		logic [7:0] d;
		logic [4:0] wb;
		logic [8:0] sp;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		rdc("rate rst", SLCR_ADDR_RATE_WIDTH, 8'hB5);
		rdc("spread rst", SLCR_ADDR_SPREAD, 8'h1F);
		cmp("cfg rst", {2'h0, 8'hB5, 8'h1F}, {2'h0, link_cfg});
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = {i[1:0], ~i[1:0], i[0], i[2:0]};
			u_slcr_ecu_model.wr(SLCR_ADDR_RATE_WIDTH, d);
			cmp("changed", 18'h1, {17'h0, cfg_changed});
			rdc("rate rw", SLCR_ADDR_RATE_WIDTH, d);
			wb = (i > 4) ? 5'h12 : 5'h0A + 5'(2 * i);
			cmp("width", {13'h0, wb},
				{13'h0, cfg_status.word_bits});
			cmp("par", {17'h0, i[0] && wb > 5'h10},
				{17'h0, cfg_status.parity_unsupported});
		end
		$display("test rate done");
		u_slcr_ecu_model.wr(SLCR_ADDR_RATE_WIDTH, 8'h35);
		for (int i = 0; i < 8; i++) begin
			case (i)
				1: sp = SLCR_SPR_1P50;
				2: sp = SLCR_SPR_1P75;
				3: sp = SLCR_SPR_2P00;
				5: sp = SLCR_SPR_3P00;
				6: sp = SLCR_SPR_3P50;
				7: sp = SLCR_SPR_4P00;
				default: sp = 9'h000;
			endcase
			u_slcr_ecu_model.wr(SLCR_ADDR_SPREAD, {i[2:0], 5'h00});
			rdc("spread rw", SLCR_ADDR_SPREAD, {i[2:0], 5'h1F});
			cmp("active", {17'h0, i[1:0] != 2'h0},
				{17'h0, cfg_status.spread_active});
			cmp("hundredths", {9'h0, sp},
				{9'h0, cfg_status.spread_hundredths});
			cmp("resv flag", 18'h0,
				{17'h0, cfg_status.reserved_not_ones});
		end
		u_slcr_ecu_model.wr(SLCR_ADDR_RATE_WIDTH, 8'hF5);
		u_slcr_ecu_model.wr(SLCR_ADDR_SPREAD, 8'hFF);
		rdc("spread cap", SLCR_ADDR_SPREAD, 8'h7F);
		cmp("over limit", 18'h0,
			{17'h0, cfg_status.spread_over_limit});
		$display("test spread done");
		u_slcr_ecu_model.wr(8'h02, 8'hAA);
		cmp("addr error", 18'h1, {17'h0, reg_addr_error});
		rdc("unmapped", 8'h02, 8'h00);
		rdc("rate kept", SLCR_ADDR_RATE_WIDTH, 8'hF5);
		$display("test unmapped done");
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		rdc("rate rst2", SLCR_ADDR_RATE_WIDTH, 8'hB5);
		rdc("spread rst2", SLCR_ADDR_SPREAD, 8'h1F);
		cmp("cfg rst2", {2'h0, 8'hB5, 8'h1F}, {2'h0, link_cfg});
		$display("test reset again done");
		results;
	end
endmodule
